/* inc/vrs_defines.svh */
// shared constants of the voltage reference sequencer
`ifndef VRS_DEFINES_SVH
`define VRS_DEFINES_SVH

// system clock period and reference slew
`define VRS_CLK_NS 100
`define VRS_STEP_UV 12500
// slew rate 3.25 mV/us, kept in uV per us
`define VRS_SLEW_UV_PER_US 3250
// least cycles between two one-unit steps, rounded up so the rate is never exceeded
`define VRS_SLEW_TICK_CYC ((`VRS_STEP_UV * 1000 + `VRS_SLEW_UV_PER_US * `VRS_CLK_NS - 1) / \
    (`VRS_SLEW_UV_PER_US * `VRS_CLK_NS))

// reference levels in 12.5 mV units
`define VRS_LVL_W 7
`define VRS_LVL_TOP 7'h7C
`define VRS_LVL_ZERO 7'h00
`define VRS_VID_OFF 7'h7C

// boot selection levels: 1.1, 1.0, 0.9, 0.8 V
`define VRS_BOOT_00 7'h58
`define VRS_BOOT_01 7'h50
`define VRS_BOOT_10 7'h48
`define VRS_BOOT_11 7'h40

// fixed levels: 1.4, 1.2, 1.0, 0.8 V
`define VRS_FIX_00 7'h70
`define VRS_FIX_01 7'h60
`define VRS_FIX_10 7'h50
`define VRS_FIX_11 7'h40

// serial address byte layout: {addr[6:0], rw}
`define VRS_ADDR_HI 3'h6
`define VRS_ADDR_CORE_BIT 3
`define VRS_ADDR_BRIDGE_BIT 2
`define VRS_BITS_PER_BYTE 4'h8

`endif

/* inc/vrs_pkg.sv */
// types of the voltage reference sequencer
package vrs_pkg;

    typedef enum logic [3:0] {
        VRS_ST_IDLE = 4'h1,
        VRS_ST_SOFT = 4'h2,
        VRS_ST_RUN  = 4'h4,
        VRS_ST_DOWN = 4'h8
    } vrs_state_e;

    typedef enum logic [3:0] {
        VRS_RX_IDLE = 4'h1,
        VRS_RX_ADDR = 4'h2,
        VRS_RX_DATA = 4'h4,
        VRS_RX_SKIP = 4'h8
    } vrs_rx_state_e;

    typedef logic [6:0] vrs_level_t;

endpackage

/* inc/vrs_cmd_if.sv */
// carrier between the serial receiver and the sequencer
interface vrs_cmd_if;
    logic listen;
    logic valid;
    logic core_sel;
    logic bridge_sel;
    logic [6:0] vid;
    logic drive_low;

    modport rx (input listen, output valid, output core_sel, output bridge_sel, output vid, output drive_low);
    modport seq (output listen, input valid, input core_sel, input bridge_sel, input vid, input drive_low);
endinterface

/* rtl/vrs_svi_rx.sv */
// serial set-vid frame receiver
`include "vrs_defines.svh"

module vrs_svi_rx import vrs_pkg::*; (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    // synchronised link pins
    input wire logic i_link_clk,
    input wire logic i_link_data,
    // command carrier
    vrs_cmd_if.rx cmd
);
    vrs_rx_state_e state;
    logic scl_q;
    logic sda_q;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic core_hit;
    logic bridge_hit;
    logic [6:0] vid_hold;

    wire start_cond = i_link_clk & scl_q & sda_q & ~i_link_data;
    wire stop_cond = i_link_clk & scl_q & ~sda_q & i_link_data;
    wire scl_rise = i_link_clk & ~scl_q;
    wire scl_fall = ~i_link_clk & scl_q;
    wire byte_done = scl_fall & (bit_cnt == `VRS_BITS_PER_BYTE) & ~cmd.drive_low;
    wire ack_done = scl_fall & cmd.drive_low;
    wire addr_ok = (shreg[7:5] == `VRS_ADDR_HI) & ~shreg[0]
        & (shreg[`VRS_ADDR_CORE_BIT] | shreg[`VRS_ADDR_BRIDGE_BIT]);

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= i_link_clk;
            sda_q <= i_link_data;
        end
    end

    // framing: start, address byte, ack, data byte, ack, stop
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state <= VRS_RX_IDLE;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
        end else if (!cmd.listen || stop_cond) begin
            state <= VRS_RX_IDLE;
            bit_cnt <= 4'h0;
        end else if (start_cond) begin
            state <= VRS_RX_ADDR;
            bit_cnt <= 4'h0;
        end else if (scl_rise && bit_cnt < `VRS_BITS_PER_BYTE && state != VRS_RX_SKIP) begin
            shreg <= {shreg[6:0], i_link_data};
            bit_cnt <= bit_cnt + 4'h1;
        end else if (byte_done && state == VRS_RX_ADDR && !addr_ok) begin
            state <= VRS_RX_SKIP;
        end else if (ack_done) begin
            bit_cnt <= 4'h0;
            state <= (state == VRS_RX_ADDR) ? VRS_RX_DATA : VRS_RX_SKIP;
        end
    end

    // ack drive: pull data low through the ninth clock of an accepted byte
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cmd.drive_low <= 1'b0;
        end else if (!cmd.listen || ack_done || start_cond || stop_cond) begin
            cmd.drive_low <= 1'b0;
        end else if (byte_done && (state == VRS_RX_DATA || (state == VRS_RX_ADDR && addr_ok))) begin
            cmd.drive_low <= 1'b1;
        end
    end

    // plane select latched from the address byte, code from the data byte
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            core_hit <= 1'b0;
            bridge_hit <= 1'b0;
            vid_hold <= 7'h00;
        end else if (byte_done && state == VRS_RX_ADDR) begin
            core_hit <= shreg[`VRS_ADDR_CORE_BIT];
            bridge_hit <= shreg[`VRS_ADDR_BRIDGE_BIT];
        end else if (byte_done && state == VRS_RX_DATA) begin
            vid_hold <= shreg[6:0];
        end
    end

    // one-cycle strobe at the end of the data acknowledge
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cmd.valid <= 1'b0;
        end else begin
            cmd.valid <= ack_done && state == VRS_RX_DATA && cmd.listen;
        end
    end

    assign cmd.core_sel = core_hit;
    assign cmd.bridge_sel = bridge_hit;
    assign cmd.vid = vid_hold;
endmodule // vrs_svi_rx

/* rtl/vrs_sequencer.sv */
// voltage reference sequencer for the core and bridge planes
//
// How it works
// - with fixed select low, link pins are read as a boot selection after reset
// - boot selection clock,data: 00=1.1V 01=1.0V 10=0.9V 11=0.8V
// - enable rising edge latches the boot level into the holding register
// - after enable both planes stair-step up to target together
// - rails good rises only after soft-start ends and both planes regulate
// - enable falling drops rails good and ramps both references to zero
// - fixed select high decodes pins as 1.4, 1.2, 1.0, 0.8 V
// - live changes on fixed select, and on link pins while fixed select is high, are followed
// - while power ok is high in run with fixed select low the serial link is watched for commands
// - a command carries plane selection and a 7-bit code
// - each addressed plane steps to its newly commanded level
// - code 0 is 1.55V, each count lowers 12.5mV, codes 7C-7F are off
// - core commanded off keeps rails good asserted
// - power ok low steps both planes to the held boot level, pins ignored
// - power ok raised again holds targets until a new command
// - rails good lost in operation ramps both references to zero
// - references slew at a fixed rate until equal to target
`include "vrs_defines.svh"

module vrs_sequencer import vrs_pkg::*; #(
    parameter int SLEW_CYC = `VRS_SLEW_TICK_CYC
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    // control pins
    input wire logic i_enable,
    input wire logic i_fixed_level_select,
    input wire logic i_host_power_ok,
    // plane regulation comparators
    input wire logic i_core_in_reg,
    input wire logic i_bridge_in_reg,
    // serial link pins
    input wire logic i_link_clk_pin,
    input wire logic i_link_data_pin,
    output logic o_link_data_pin,
    output logic o_link_data_pin_oe_n,
    // references and status
    output logic [6:0] o_core_ref,
    output logic [6:0] o_bridge_ref,
    output logic o_rails_good
);
    localparam int NSYNC = 7;
    localparam int PLANES = 2;

    initial begin
        if (SLEW_CYC < 1 || SLEW_CYC > 65535) begin
            $error("SLEW_CYC out of range");
        end
    end

    // every pin passes two flip-flops; the first stage is read by the second only
    logic [NSYNC-1:0] sync_a;
    logic [NSYNC-1:0] sync_b;
    wire [NSYNC-1:0] pins_raw = {i_enable, i_fixed_level_select, i_host_power_ok, i_core_in_reg,
        i_bridge_in_reg, i_link_clk_pin, i_link_data_pin};

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sync_a <= 7'h03;
            sync_b <= 7'h03;
        end else begin
            sync_a <= pins_raw;
            sync_b <= sync_a;
        end
    end

    wire en_s = sync_b[6];
    wire fix_s = sync_b[5];
    wire pok_s = sync_b[4];
    wire core_reg_s = sync_b[3];
    wire bridge_reg_s = sync_b[2];
    wire lclk_s = sync_b[1];
    wire ldata_s = sync_b[0];

    logic en_q;
    logic pok_q;
    wire en_rise = en_s & ~en_q;
    wire pok_rise = pok_s & ~pok_q;

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            en_q <= 1'b0;
            pok_q <= 1'b0;
        end else begin
            en_q <= en_s;
            pok_q <= pok_s;
        end
    end

    // pin decodes
    vrs_level_t boot_dec;
    vrs_level_t fix_dec;

    always_comb begin
        unique case ({lclk_s, ldata_s})
            2'b00: boot_dec = `VRS_BOOT_00;
            2'b01: boot_dec = `VRS_BOOT_01;
            2'b10: boot_dec = `VRS_BOOT_10;
            2'b11: boot_dec = `VRS_BOOT_11;
        endcase
    end

    always_comb begin
        unique case ({lclk_s, ldata_s})
            2'b00: fix_dec = `VRS_FIX_00;
            2'b01: fix_dec = `VRS_FIX_01;
            2'b10: fix_dec = `VRS_FIX_10;
            2'b11: fix_dec = `VRS_FIX_11;
        endcase
    end

    function automatic vrs_level_t vid_to_level(input logic [6:0] vid);
        vrs_level_t lvl;
        lvl = (vid >= `VRS_VID_OFF) ? `VRS_LVL_ZERO : `VRS_LVL_TOP - vid;
        return lvl;
    endfunction

    // holding register for the start-up level
    vrs_level_t hold_level;

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            hold_level <= `VRS_LVL_ZERO;
        end else if (en_rise) begin
            hold_level <= fix_s ? fix_dec : boot_dec;
        end
    end

    // fixed mode tracks the live pins; boot mode keeps the stored value and rereads pins only on an enable rising edge
    wire vrs_level_t mode_level = fix_s ? fix_dec : hold_level;

    // sequencer state
    vrs_state_e state;
    vrs_state_e next_state;
    vrs_level_t ref_lvl [PLANES];
    vrs_level_t tgt_lvl [PLANES];
    vrs_level_t svi_lvl [PLANES];
    logic rails_good;

    wire svi_mode = (state == VRS_ST_RUN) & pok_s & ~fix_s;
    wire refs_zero = (ref_lvl[0] == `VRS_LVL_ZERO) & (ref_lvl[1] == `VRS_LVL_ZERO);
    wire refs_done = (ref_lvl[0] == tgt_lvl[0]) & (ref_lvl[1] == tgt_lvl[1]);
    // an intentionally switched-off core is not a regulation fault
    wire core_ok = core_reg_s | (tgt_lvl[0] == `VRS_LVL_ZERO);
    wire planes_ok = core_ok & bridge_reg_s;

    always_comb begin
        next_state = state;
        unique case (state)
            VRS_ST_IDLE: begin
                if (en_rise) begin
                    next_state = VRS_ST_SOFT;
                end
            end
            VRS_ST_SOFT: begin
                if (!en_s) begin
                    next_state = VRS_ST_DOWN;
                end else if (refs_done && core_reg_s && bridge_reg_s) begin
                    next_state = VRS_ST_RUN;
                end
            end
            VRS_ST_RUN: begin
                if (!en_s || !planes_ok) begin
                    next_state = VRS_ST_DOWN;
                end
            end
            VRS_ST_DOWN: begin
                if (refs_zero) begin
                    next_state = VRS_ST_IDLE;
                end
            end
            default: next_state = VRS_ST_DOWN;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state <= VRS_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // rails good follows the run state and drops in the same cycle that run is left
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rails_good <= 1'b0;
        end else begin
            rails_good <= (next_state == VRS_ST_RUN);
        end
    end

    // serial command link
    vrs_cmd_if cmd ();

    assign cmd.listen = svi_mode;

    vrs_svi_rx u_rx (
        .i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .i_link_clk(lclk_s),
        .i_link_data(ldata_s),
        .cmd(cmd)
    );

    // per-plane commanded level; tracks the mode level until serial control starts
    logic [PLANES-1:0] plane_sel;
    assign plane_sel = {cmd.bridge_sel, cmd.core_sel};

    // slew tick shared by both planes
    logic [15:0] tick_cnt;
    wire slew_tick = (tick_cnt == 16'(SLEW_CYC - 1));

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            tick_cnt <= 16'h0000;
        end else if (slew_tick) begin
            tick_cnt <= 16'h0000;
        end else begin
            tick_cnt <= tick_cnt + 16'h0001;
        end
    end

    genvar p;
    generate
        for (p = 0; p < PLANES; p++) begin : g_plane
            always_ff @(posedge i_sys_clk or negedge i_resetn) begin
                if (!i_resetn) begin
                    svi_lvl[p] <= `VRS_LVL_ZERO;
                end else if (!svi_mode) begin
                    svi_lvl[p] <= mode_level;
                end else if (cmd.valid && plane_sel[p]) begin
                    svi_lvl[p] <= vid_to_level(cmd.vid);
                end
            end

            always_comb begin
                unique case (state)
                    VRS_ST_SOFT: tgt_lvl[p] = mode_level;
                    VRS_ST_RUN: tgt_lvl[p] = svi_mode ? svi_lvl[p] : mode_level;
                    default: tgt_lvl[p] = `VRS_LVL_ZERO;
                endcase
            end

            // one unit per tick toward the target, so transition time scales with the change
            always_ff @(posedge i_sys_clk or negedge i_resetn) begin
                if (!i_resetn) begin
                    ref_lvl[p] <= `VRS_LVL_ZERO;
                end else if (slew_tick && ref_lvl[p] < tgt_lvl[p]) begin
                    ref_lvl[p] <= ref_lvl[p] + 7'h01;
                end else if (slew_tick && ref_lvl[p] > tgt_lvl[p]) begin
                    ref_lvl[p] <= ref_lvl[p] - 7'h01;
                end
            end
        end
    endgenerate

    // outputs
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_link_data_pin <= 1'b0;
            o_link_data_pin_oe_n <= 1'b1;
        end else begin
            o_link_data_pin <= 1'b0;
            o_link_data_pin_oe_n <= ~cmd.drive_low;
        end
    end

    assign o_core_ref = ref_lvl[0];
    assign o_bridge_ref = ref_lvl[1];
    assign o_rails_good = rails_good;
endmodule // vrs_sequencer

/* tb/vrs_sequencer_asserts.sv */
// port assertions of the voltage reference sequencer
module vrs_sequencer_asserts #(
    parameter int SLEW_CYC = 39
) (
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic i_enable,
    input wire logic i_bridge_in_reg,
    input wire logic o_link_data_pin_oe_n,
    input wire logic [6:0] o_core_ref,
    input wire logic [6:0] o_bridge_ref,
    input wire logic o_rails_good
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [6:0] core_prev;
    int gap;
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_resetn);

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            core_prev <= 7'h00;
        end else begin
            core_prev <= o_core_ref;
        end
    end

    // cycles since the core reference last moved
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            gap <= SLEW_CYC;
        end else if (o_core_ref != core_prev) begin
            gap <= 1;
        end else begin
            gap <= gap + 1;
        end
    end

    chk_core_unit: assert property (
        (o_core_ref - core_prev) inside {7'h00, 7'h01, 7'h7F}) else $error("core step too large");
    chk_bridge_unit: assert property (
        (o_bridge_ref - $past(o_bridge_ref)) inside {7'h00, 7'h01, 7'h7F}) else $error("bridge step too large");
    chk_core_rate: assert property (
        (o_core_ref != core_prev) |-> gap >= SLEW_CYC) else $error("core slews too fast");
    chk_good_drop: assert property (
        $fell(i_enable) |-> ##[1:6] !o_rails_good) else $error("rails good kept after enable loss");
    chk_idle_down: assert property (
        (!i_enable) [*6] |-> o_core_ref <= core_prev) else $error("core rises while disabled");
    chk_good_cause: assert property (
        $rose(o_rails_good) |-> i_enable && o_core_ref != 7'h00 && o_bridge_ref != 7'h00)
        else $error("rails good before soft start done");
    chk_reg_loss: assert property (
        (!i_bridge_in_reg) [*5] |-> !o_rails_good) else $error("rails good kept without regulation");
    chk_ack_run: assert property (
        !o_link_data_pin_oe_n |-> o_rails_good) else $error("ack outside run");
    chk_ack_hold: assert property (
        $fell(o_link_data_pin_oe_n) |=> (!o_link_data_pin_oe_n) [*6]) else $error("ack too short");
endmodule // vrs_sequencer_asserts

/* tb/vrs_host_model.sv */
// host side of the serial link: straps, frames and ack sampling
module vrs_host_model #(
    parameter int HALF_NS = 400
) (
    // wire level seen on the data line
    input wire logic i_wire_data,
    // host drive
    output logic o_link_clk,
    output logic o_pull_low
);
    timeunit 1ns;
    timeprecision 1ns;
    logic acked;

    initial begin
        o_link_clk = 1'b1;
        o_pull_low = 1'b0;
        acked = 1'b1;
    end

    // a strap holds clock level first, data level second; 11 is the idle link
    task automatic strap(input logic [1:0] code);
        o_link_clk = code[1];
        o_pull_low = !code[0];
    endtask

    task automatic put_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            o_link_clk = 1'b0;
            o_pull_low = !b[i];
            #HALF_NS o_link_clk = 1'b1;
            #HALF_NS;
        end
        o_link_clk = 1'b0;
        o_pull_low = 1'b0;
        #HALF_NS o_link_clk = 1'b1;
        // sampled late in the high phase so a lagging ack still counts
        #(HALF_NS - 50) acked = acked & !i_wire_data;
        #50;
    endtask

    task automatic frame(input logic [7:0] a, input logic [7:0] d);
        acked = 1'b1;
        o_link_clk = 1'b1;
        o_pull_low = 1'b0;
        #HALF_NS o_pull_low = 1'b1;
        #HALF_NS;
        put_byte(a);
        put_byte(d);
        o_link_clk = 1'b0;
        o_pull_low = 1'b1;
        #HALF_NS o_link_clk = 1'b1;
        #HALF_NS o_pull_low = 1'b0;
        #HALF_NS;
    endtask
endmodule // vrs_host_model

/* tb/testbench.sv */
// self-checking bench of the voltage reference sequencer
module testbench import vrs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SLEW = 3;
    logic i_sys_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic en = 1'b0, fix = 1'b0, pok = 1'b0, creg = 1'b1, breg = 1'b1;
    logic lclk, pull, dout, doe_n, good;
    logic [6:0] cref, bref;
    wire wdata = !pull && (doe_n || dout);
    int fails = 0, compares = 0;

    always #50 i_sys_clk = !i_sys_clk;

    vrs_sequencer #(.SLEW_CYC(SLEW)) i_vrs_sequencer (
        .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_enable(en),
        .i_fixed_level_select(fix), .i_host_power_ok(pok),
        .i_core_in_reg(creg), .i_bridge_in_reg(breg),
        .i_link_clk_pin(lclk), .i_link_data_pin(wdata),
        .o_link_data_pin(dout), .o_link_data_pin_oe_n(doe_n),
        .o_core_ref(cref), .o_bridge_ref(bref), .o_rails_good(good));

    vrs_host_model i_vrs_host_model (.i_wire_data(wdata), .o_link_clk(lclk), .o_pull_low(pull));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge i_sys_clk);
        #10;
    endtask

    // bounded poll so a stuck ramp cannot hang the run
    task automatic wait_refs(input vrs_level_t c, input vrs_level_t b);
        for (int i = 0; i < 2000 && !(cref === c && bref === b); i++) cyc(1);
        chk(cref, c);
        chk(bref, b);
    endtask

    task automatic t_start(input logic f, input logic [1:0] code, input vrs_level_t lvl);
        fix = f;
        i_vrs_host_model.strap(code);
        cyc(4);
        en = 1'b1;
        cyc(2);
        chk(good, 1'b0);
        wait_refs(lvl, lvl);
        cyc(4);
        chk(good, 1'b1);
    endtask

    task automatic t_stop();
        en = 1'b0;
        cyc(6);
        chk(good, 1'b0);
        wait_refs(7'h00, 7'h00);
        cyc(4);
    endtask

    task automatic t_modes();
        vrs_level_t lv[8] = '{7'h58, 7'h50, 7'h48, 7'h40, 7'h70, 7'h60, 7'h50, 7'h40};
        for (int m = 0; m < 8; m++) begin
            t_start(m[2], m[1:0], lv[m]);
            t_stop();
        end
    endtask

    task automatic t_live();
        t_start(1'b1, 2'b00, 7'h70);
        i_vrs_host_model.strap(2'b11);
        wait_refs(7'h40, 7'h40);
        t_stop();
    endtask

    task automatic t_svi();
        logic [7:0] bad[3] = '{8'hC9, 8'hC0, 8'h48};
        t_start(1'b0, 2'b00, 7'h58);
        i_vrs_host_model.strap(2'b11);
        i_vrs_host_model.frame(8'hC8, 8'h10);
        chk(i_vrs_host_model.acked, 1'b0);
        pok = 1'b1;
        cyc(4);
        i_vrs_host_model.frame(8'hC8, 8'h10);
        chk(i_vrs_host_model.acked, 1'b1);
        wait_refs(7'h6C, 7'h58);
        i_vrs_host_model.frame(8'hC4, 8'h00);
        wait_refs(7'h6C, 7'h7C);
        i_vrs_host_model.frame(8'hCC, 8'h2C);
        wait_refs(7'h50, 7'h50);
        // bridge stays on while core is off
        i_vrs_host_model.frame(8'hC8, 8'h7E);
        creg = 1'b0;
        wait_refs(7'h00, 7'h50);
        chk(good, 1'b1);
        for (int i = 0; i < 3; i++) begin
            i_vrs_host_model.frame(bad[i], 8'h10);
            chk(i_vrs_host_model.acked, 1'b0);
        end
        chk(bref, 7'h50);
        creg = 1'b1;
        pok = 1'b0;
        i_vrs_host_model.strap(2'b01);
        wait_refs(7'h58, 7'h58);
        pok = 1'b1;
        cyc(60);
        chk(cref, 7'h58);
        chk(bref, 7'h58);
        breg = 1'b0;
        cyc(8);
        chk(good, 1'b0);
        wait_refs(7'h00, 7'h00);
        breg = 1'b1;
        pok = 1'b0;
        t_stop();
    endtask

    task automatic conclude();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        cyc(8);
        i_resetn = 1'b1;
        cyc(2);
        t_modes();
        t_live();
        t_svi();
        conclude();
    end

    // the whole run needs about 0.75 ms, a quarter of the 3 ms limit
    initial begin
        #3000000;
        fails++;
        conclude();
    end
endmodule // testbench

bind vrs_sequencer vrs_sequencer_asserts #(.SLEW_CYC(SLEW_CYC)) i_vrs_sequencer_asserts (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_enable(i_enable),
    .i_bridge_in_reg(i_bridge_in_reg), .o_link_data_pin_oe_n(o_link_data_pin_oe_n),
    .o_core_ref(o_core_ref), .o_bridge_ref(o_bridge_ref), .o_rails_good(o_rails_good));
